/* File: common/urs_defines.svh */
// Operation
// - Sample the receive line on a tick running sixteen times the baud rate.
// - Resync the tick count after each start bit and each 1-to-0 bit change outside ticks 8 to 10.
// - Start search wants a 0 after three 1s; the edge starts counting to 16.
// - Start verified by ticks 3,5,7; one 1 sets noise; two or more reject.
// - A rejected start resets the tick count and restarts the search.
// - Data bit is the majority of ticks 8,9,10; disagreement sets noise.
// - Start-bit ticks 8 to 10 only add noise, never cancel the start bit.
// - Stop bit majority 0 sets framing error; disagreement sets noise.
// - A break character sets framing error like a missing stop bit.
// - Framing error rises in the same cycle as receive full.
// - A falling edge after a 1 bit realigns the tick count unless it lands on ticks 8 to 10.
// - A slow stop bit starting at tick 8 still receives cleanly.
// - A fast stop bit ending at tick 10 still receives cleanly.
// - Standby bit suppresses all receiver interrupt requests.
// - Address-mark wake: MSB 1 clears standby and sets receive full.
// - Idle wake: idle character clears standby, sets neither idle nor full.
// - Idle type decides whether the ones count starts after start or stop.
// - Idle wake: setting standby on an already idle line wakes at once.
// - Idle flag rises after 10 or 11 consecutive ones, per length.
// - Wake select 1 is address mark, 0 idle line; reset clears it.
// - Idle type 1 counts after the stop bit, 0 after the start bit.
// - Length bit set gives 9-bit characters, clear gives 8-bit.
`ifndef URS_DEFINES_SVH
`define URS_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define URS_OFS_CTRL    8'h00
`define URS_OFS_STAT    8'h04
`define URS_OFS_DATA    8'h08
`define URS_OFS_BAUD    8'h0C

`define URS_CTRL_EN     0
`define URS_CTRL_LEN9   1
`define URS_CTRL_WAKE   2
`define URS_CTRL_IDLE_COUNT_START_SELECT   3
`define URS_CTRL_STBY   4

`define URS_STAT_FULL   0
`define URS_STAT_NOISE  1
`define URS_STAT_FRAME  2
`define URS_STAT_IDLE   3
`define URS_STAT_ACTIVE 4
`define URS_STAT_STBY   5

`define URS_CTRL_RST    5'h00
`define URS_BAUD_RST    16'h001A

// ----------------------------------------------------------------
// Oversample tick positions within a bit
// ----------------------------------------------------------------
`define URS_RT_FIRST    5'h01
`define URS_RT_V1       5'h03
`define URS_RT_V2       5'h05
`define URS_RT_V3       5'h07
`define URS_RT_S1       5'h08
`define URS_RT_S2       5'h09
`define URS_RT_S3       5'h0A
`define URS_RT_LAST     5'h10
`define URS_IDLE_TK8    8'hA0
`define URS_IDLE_TK9    8'hB0

`endif

/* File: common/urs_pkg.sv */
package urs_pkg;

   typedef enum logic [1:0] {
      URS_SEARCH,
      URS_START,
      URS_DATA,
      URS_STOP
   } urs_state_t;

   typedef struct packed {
      logic       standby;
      logic       idleAfterStop;
      logic       wakeAddr;
      logic       lenNine;
      logic       enable;
   } urs_ctrl_t;

   typedef struct packed {
      logic       idle;
      logic       frame;
      logic       noise;
      logic       full;
   } urs_stat_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } urs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } urs_apb_rsp_t;

   typedef struct packed {
      logic [2:0]  sync;
      logic        filt;
      logic [15:0] divCnt;
      urs_state_t  st;
      logic [4:0]  rt;
      logic [3:0]  bitIdx;
      logic [2:0]  hist;
      logic [2:0]  vote;
      logic [8:0]  shift;
      logic        noiseAcc;
      logic        lastOne;
      logic [7:0]  idleCnt;
      logic        idleDone;
      urs_ctrl_t   ctrl;
      logic [15:0] baud;
      urs_stat_t   stat;
      logic [8:0]  data;
      logic [31:0] rdata;
      logic        err;
   } urs_regs_t;

endpackage : urs_pkg

/* File: design/urs_rx_sampler.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "urs_defines.svh"

module urs_rx_sampler #(
   parameter logic [15:0] BAUD_DIV_RST = `URS_BAUD_RST
) (
   input  wire logic                  clk,         // 50 MHz clock
   input  wire logic                  rst_b,       // Sync reset, low
   input  wire urs_pkg::urs_apb_req_t apbReq,      // APB request
   output urs_pkg::urs_apb_rsp_t      apbRsp,      // APB response
   input  wire logic                  rxPin,       // Receive line
   output logic                       rxEventReq,  // Receiver request
   output logic                       rxActive     // Character in progress
);
   import urs_pkg::*;

   urs_regs_t s;
   urs_regs_t n;

   logic       tick;
   logic       smp;
   logic       fall;
   logic [4:0] cur;
   logic [2:0] v;
   logic       maj;
   logic       dis;
   logic       vOk;
   logic       commit;
   logic       msb;
   logic       idleEv;
   logic [7:0] idleLim;
   logic [3:0] stopIdx;
   logic       setup;
   logic       access;

   function automatic logic maj3(input logic [2:0] x);
      maj3 = (x[0] & x[1]) | (x[0] & x[2]) | (x[1] & x[2]);
   endfunction : maj3

   // ----------------------------------------------------------------
   // Combinational next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n       = s;
      commit  = 1'b0;
      idleEv  = 1'b0;
      fall    = 1'b0;
      cur     = 5'h00;
      v       = 3'h0;
      maj     = 1'b0;
      dis     = 1'b0;
      vOk     = 1'b0;
      msb     = s.shift[8];
      stopIdx = s.ctrl.lenNine ? 4'hA : 4'h9;
      idleLim = s.ctrl.lenNine ? `URS_IDLE_TK9 : `URS_IDLE_TK8;
      setup   = apbReq.psel & ~apbReq.penable;
      access  = apbReq.psel & apbReq.penable;

      // Pin passes three flops; a change is taken once two and three agree
      n.sync = {s.sync[1:0], rxPin};
      if (s.sync[1] == s.sync[2])
      begin
         n.filt = s.sync[2];
      end
      smp = s.filt;

      // Oversample tick generator, sixteen ticks per bit
      tick = (s.divCnt == 16'h0000);
      n.divCnt = tick ? s.baud : s.divCnt - 16'h0001;

      if (!s.ctrl.enable)
      begin
         n.st       = URS_SEARCH;
         n.rt       = 5'h00;
         n.hist     = 3'h0;
         n.idleCnt  = 8'h00;
         n.idleDone = 1'b0;
      end
      else if (tick)
      begin
         n.hist = {s.hist[1:0], smp};
         fall   = s.hist[0] & ~smp;
         // ----------------------------------------------------------
         // Idle line detection
         // ----------------------------------------------------------
         if (!smp || (s.ctrl.idleAfterStop && s.st != URS_SEARCH))
         begin
            n.idleCnt = 8'h00;
            if (!smp)
            begin
               n.idleDone = 1'b0;
            end
         end
         else if (!s.idleDone)
         begin
            // Ones count; with IDLE_COUNT_START_SELECT clear the data and stop bits count
            n.idleCnt = s.idleCnt + 8'h01;
            if (n.idleCnt == idleLim)
            begin
               n.idleDone = 1'b1;
               idleEv     = 1'b1;
            end
         end

         // ----------------------------------------------------------
         // Start search and bit sampling
         // ----------------------------------------------------------
         if (s.st == URS_SEARCH)
         begin
            if (s.hist == 3'b111 && !smp)
            begin
               n.st       = URS_START;
               n.rt       = `URS_RT_FIRST;
               n.bitIdx   = 4'h0;
               n.noiseAcc = 1'b0;
               n.lastOne  = 1'b0;
               n.shift    = 9'h000;
            end
         end
         else
         begin
            cur = (s.rt == `URS_RT_LAST) ? `URS_RT_FIRST : s.rt + 5'h01;
            if (s.rt == `URS_RT_LAST)
            begin
               n.bitIdx = s.bitIdx + 4'h1;
            end
            // Edge after a 1 bit realigns the count to the bit start
            if (s.lastOne && fall && s.st != URS_START)
            begin
               if (cur > `URS_RT_S3 && s.rt != `URS_RT_LAST)
               begin
                  n.bitIdx = s.bitIdx + 4'h1;
               end
               if (cur > `URS_RT_S3 || cur < `URS_RT_S1)
               begin
                  cur = `URS_RT_FIRST;
               end
            end
            n.rt = cur;
            if (cur == `URS_RT_FIRST)
            begin
               n.st = (n.bitIdx == stopIdx) ? URS_STOP : URS_DATA;
            end
            v = {s.vote[1:0], smp};
            if (cur == `URS_RT_V1 || cur == `URS_RT_V2 ||
                cur == `URS_RT_S1 || cur == `URS_RT_S2)
            begin
               n.vote = v;
            end
            maj = maj3(v);
            dis = (|v) & ~(&v);
            vOk = ~maj;
            if (s.st == URS_START && cur == `URS_RT_V3)
            begin
               if (vOk)
               begin
                  n.noiseAcc = |v;
               end
               else
               begin
                  n.st = URS_SEARCH;
                  n.rt = 5'h00;
               end
            end
            if (cur == `URS_RT_S3)
            begin
               case (s.st)
                  URS_START:
                  begin
                     // Late start samples add noise only
                     n.noiseAcc = s.noiseAcc | (|v);
                  end
                  URS_DATA:
                  begin
                     n.shift    = {maj, s.shift[8:1]};
                     n.noiseAcc = s.noiseAcc | dis;
                     n.lastOne  = maj;
                  end
                  URS_STOP:
                  begin
                     // Leave at tick 10 so a short stop bit still passes
                     commit = 1'b1;
                     n.st   = URS_SEARCH;
                     n.rt   = 5'h00;
                  end
                  default:
                  begin
                     n.st = URS_SEARCH;
                  end
               endcase
            end
         end
      end

      // ----------------------------------------------------------------
      // Register bus
      // ----------------------------------------------------------------
      if (setup)
      begin
         n.err   = 1'b0;
         n.rdata = 32'h0000_0000;
         if (apbReq.paddr == `URS_OFS_CTRL)
         begin
            n.rdata[4:0] = s.ctrl;
         end
         else if (apbReq.paddr == `URS_OFS_STAT)
         begin
            n.rdata[`URS_STAT_FULL]   = s.stat.full;
            n.rdata[`URS_STAT_NOISE]  = s.stat.noise;
            n.rdata[`URS_STAT_FRAME]  = s.stat.frame;
            n.rdata[`URS_STAT_IDLE]   = s.stat.idle;
            n.rdata[`URS_STAT_ACTIVE] = (s.st != URS_SEARCH);
            n.rdata[`URS_STAT_STBY]   = s.ctrl.standby;
         end
         else if (apbReq.paddr == `URS_OFS_DATA)
         begin
            n.rdata[8:0] = s.data;
         end
         else if (apbReq.paddr == `URS_OFS_BAUD)
         begin
            n.rdata[15:0] = s.baud;
         end
         else
         begin
            n.err = 1'b1;
         end
      end

      // Software effects first, hardware sets after them so sets win
      if (access && !s.err)
      begin
         if (apbReq.pwrite && apbReq.paddr == `URS_OFS_CTRL)
         begin
            n.ctrl.enable        = apbReq.pwdata[`URS_CTRL_EN];
            n.ctrl.lenNine       = apbReq.pwdata[`URS_CTRL_LEN9];
            n.ctrl.wakeAddr      = apbReq.pwdata[`URS_CTRL_WAKE];
            n.ctrl.idleAfterStop = apbReq.pwdata[`URS_CTRL_IDLE_COUNT_START_SELECT];
            n.ctrl.standby       = apbReq.pwdata[`URS_CTRL_STBY];
         end
         else if (apbReq.pwrite && apbReq.paddr == `URS_OFS_STAT)
         begin
            if (apbReq.pwdata[`URS_STAT_NOISE])
            begin
               n.stat.noise = 1'b0;
            end
            if (apbReq.pwdata[`URS_STAT_FRAME])
            begin
               n.stat.frame = 1'b0;
            end
            if (apbReq.pwdata[`URS_STAT_IDLE])
            begin
               n.stat.idle = 1'b0;
            end
         end
         else if (apbReq.pwrite && apbReq.paddr == `URS_OFS_BAUD)
         begin
            n.baud = apbReq.pwdata[15:0];
         end
         else if (!apbReq.pwrite && apbReq.paddr == `URS_OFS_DATA)
         begin
            n.stat.full = 1'b0;
         end
      end

      // ----------------------------------------------------------------
      // Character hand-over and wakeup
      // ----------------------------------------------------------------
      if (commit)
      begin
         if (!s.ctrl.standby || (s.ctrl.wakeAddr && msb))
         begin
            // Break gives all zeros: data cleared, stop 0 flags framing
            n.data       = s.ctrl.lenNine ? s.shift : {1'b0, s.shift[8:1]};
            n.stat.full  = 1'b1;
            n.stat.frame = n.stat.frame | ~maj;
            n.stat.noise = n.stat.noise | s.noiseAcc | dis;
            if (s.ctrl.standby)
            begin
               n.ctrl.standby = 1'b0;
            end
         end
      end
      if (idleEv)
      begin
         if (s.ctrl.standby && !s.ctrl.wakeAddr)
         begin
            n.ctrl.standby = 1'b0;
         end
         else if (!s.ctrl.standby)
         begin
            n.stat.idle = 1'b1;
         end
      end
      // Standby on a line already idle ends at once
      if (s.ctrl.standby && !s.ctrl.wakeAddr && s.idleDone)
      begin
         n.ctrl.standby = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s        <= '0;
         s.sync   <= 3'h7;
         s.filt   <= 1'b1;
         s.hist   <= 3'h0;
         s.st     <= URS_SEARCH;
         s.ctrl   <= `URS_CTRL_RST;
         s.baud   <= BAUD_DIV_RST;
      end
      else
      begin
         s <= n;
      end
   end

   // Standby holds back every receiver request
   assign rxEventReq = ~s.ctrl.standby &
                       (s.stat.full | s.stat.idle |
                        s.stat.noise | s.stat.frame);
   assign rxActive   = (s.st != URS_SEARCH);
   assign apbRsp.prdata  = s.rdata;
   assign apbRsp.pready  = access;
   assign apbRsp.pslverr = access & s.err;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence sq_edge;
      tick && s.ctrl.enable && s.st == URS_SEARCH &&
      s.hist == 3'b111 && !smp;
   endsequence

   sequence sq_armed;
      s.st == URS_START && s.rt == `URS_RT_FIRST;
   endsequence

   a_start_edge: assert property (sq_edge |=> sq_armed)
      else $error("start edge did not arm the bit counter");

   a_start_reject: assert property (
      tick && s.st == URS_START && cur == `URS_RT_V3 && maj
      |=> s.st == URS_SEARCH && s.rt == 5'h00)
      else $error("rejected start bit not dropped");

   a_start_noise: assert property (
      tick && s.st == URS_START && cur == `URS_RT_V3 && !maj && (|v)
      |=> s.noiseAcc)
      else $error("single-one start pattern missed noise");

   a_late_start: assert property (
      tick && s.st == URS_START && cur == `URS_RT_S3 && (|v)
      |=> s.noiseAcc && s.st == URS_START)
      else $error("late start samples mishandled");

   a_data_vote: assert property (
      tick && s.st == URS_DATA && cur == `URS_RT_S3
      |=> s.shift[8] == $past(maj) &&
          (s.noiseAcc || !$past(dis)))
      else $error("data majority or noise wrong");

   a_frame_full: assert property (
      $rose(s.stat.frame) |-> $rose(s.stat.full))
      else $error("framing error without receive full");

   a_stop_frame: assert property (
      commit && !s.ctrl.standby && !maj |=> s.stat.frame && s.stat.full)
      else $error("zero stop bit not flagged");

   a_standby_quiet: assert property (
      s.ctrl.standby |-> !rxEventReq)
      else $error("request raised in standby");

   a_addr_wake: assert property (
      commit && s.ctrl.standby && s.ctrl.wakeAddr && msb
      |=> !s.ctrl.standby && s.stat.full)
      else $error("address mark did not wake");

   a_idle_wake: assert property (
      idleEv && s.ctrl.standby && !s.ctrl.wakeAddr
      |=> !s.ctrl.standby && $stable(s.stat.idle))
      else $error("waking idle handled wrong");

   a_sync_agree: assert property (
      $changed(s.filt) |-> $past(s.sync[1]) == $past(s.sync[2]))
      else $error("line filter moved without agreement");

   a_tick_reload: assert property (
      tick |=> s.divCnt == $past(s.baud))
      else $error("tick divider did not reload");

endmodule : urs_rx_sampler

/* File: tb/urs_serial_tx.sv */
`timescale 1ns/1ps

module urs_serial_tx (
   input  wire logic clk,   // Bench clock
   output logic      line   // Serial line into the receiver
);
   initial line = 1'b1;

   // Start, nBits data LSB first, stop. One bit may be inverted for four
   // clocks at offset gOfs to model a noise hit on the line.
   task automatic send(input logic [8:0] val, input int nBits,
                       input int per, input logic stopVal,
                       input int gBit, input int gOfs);
      logic v;
      for (int b = 0; b <= nBits + 1; b++)
      begin
         v = (b == 0) ? 1'b0 : (b <= nBits) ? val[b-1] : stopVal;
         for (int c = 0; c < per; c++)
         begin
            @(posedge clk);
            line <= (b == gBit && c >= gOfs && c < gOfs + 4) ? ~v : v;
         end
      end
      @(posedge clk);
      line <= 1'b1;
   endtask : send

   // A low pulse too short to pass as a start bit
   task automatic pulse(input int n);
      @(posedge clk);
      line <= 1'b0;
      repeat (n) @(posedge clk);
      line <= 1'b1;
   endtask : pulse
endmodule : urs_serial_tx

/* File: tb/uart_rx_sampling_wakeup_tb_top.sv */
`timescale 1ns/1ps
`include "urs_defines.svh"

module uart_rx_sampling_wakeup_tb_top;
   import urs_pkg::*;

   logic         clk;
   logic         rst_b;
   urs_apb_req_t apbReq;
   urs_apb_rsp_t apbRsp;
   logic         rxPin;
   logic         rxEventReq;
   logic         rxActive;
   logic [31:0]  rd;
   logic         err;
   int           mismatches;
   int           n_checks;

   // Characters: value, bit period in clocks, noisy bit and its offset
   logic [8:0]   rxDat [10] = '{9'h0A5, 9'h000, 9'h0FF, 9'h055, 9'h05A,
                                9'h05A, 9'h05A, 9'h05A, 9'h000, 9'h05A};
   int           rxPer [10] = '{64, 66, 62, 60, 64, 64, 64, 64, 64, 64};
   int           glBit [10] = '{-1, -1, -1, -1, 1, 0, 0, 9, -1, -1};
   int           glOfs [10] = '{0, 0, 0, 0, 32, 16, 32, 32, 0, 0};
   int           rxSt  [10] = '{1, 1, 1, 1, 3, 3, 3, 3, 5, 5};
   logic [9:0]   stopLvl    = 10'h0FF;
   logic [31:0]  amCtl [2]  = '{32'h00000015, 32'h00000017};
   logic [8:0]   amDrop [2] = '{9'h012, 9'h0FF};
   logic [8:0]   amWake [2] = '{9'h092, 9'h100};

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   urs_rx_sampler dut (
      .clk        (clk),
      .rst_b      (rst_b),
      .apbReq     (apbReq),
      .apbRsp     (apbRsp),
      .rxPin      (rxPin),
      .rxEventReq (rxEventReq),
      .rxActive   (rxActive)
   );

   urs_serial_tx tx (
      .clk  (clk),
      .line (rxPin)
   );

   // ----------------
   // Bench tasks
   // ----------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic apb(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata);
      int n;
      @(posedge clk);
      apbReq.psel    <= 1'b1;
      apbReq.pwrite  <= wr;
      apbReq.paddr   <= addr;
      apbReq.pwdata  <= wdata;
      @(posedge clk);
      apbReq.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (apbRsp.pready !== 1'b1 && n < 20);
      if (apbRsp.pready !== 1'b1)
      begin
         mismatches++;
         end_of_test();
      end
      rd  = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel    <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb

   // Polls status until a character has landed; bounded
   task automatic waitFull();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, `URS_OFS_STAT, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b1 && n < 400);
      if (rd[0] !== 1'b1)
      begin
         mismatches++;
         end_of_test();
      end
   endtask : waitFull

   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      apbReq     = '0;
      rst_b      = 1'b0;
      mismatches = 0;
      n_checks   = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, `URS_OFS_CTRL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `URS_OFS_BAUD, 32'h0);
      check(rd, {16'h0, `URS_BAUD_RST});
      apb(1'b0, `URS_OFS_STAT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check({31'h0, err}, 32'h1);
      check({31'h0, rxEventReq}, 32'h0);
      $display("test reset done");

      // Four clocks per tick keeps a noise hit on exactly one sample
      apb(1'b1, `URS_OFS_BAUD, 32'h3);
      apb(1'b1, `URS_OFS_CTRL, 32'h1);
      repeat (100) @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
         // A zero stop bit leaves no ones behind; give the search three
         repeat (20) @(posedge clk);
         fork
            tx.send(rxDat[i], 8, rxPer[i], stopLvl[i], glBit[i], glOfs[i]);
            begin
               repeat (300) @(posedge clk);
               check({31'h0, rxActive}, 32'h1);
            end
         join
         waitFull();
         check({31'h0, rxActive}, 32'h0);
         check({31'h0, rxEventReq}, 32'h1);
         check(rd & 32'h7, 32'(rxSt[i]));
         apb(1'b0, `URS_OFS_DATA, 32'h0);
         check(rd, {23'h0, rxDat[i]});
         apb(1'b1, `URS_OFS_STAT, 32'hE);
      end
      $display("test characters done");

      // Pulses of two and three ticks fail verification
      for (int k = 2; k < 4; k++)
      begin
         repeat (40) @(posedge clk);
         tx.pulse(4 * k);
         repeat (40) @(posedge clk);
         tx.send(9'h0C3, 8, 64, 1'b1, -1, 0);
         waitFull();
         check(rd & 32'h7, 32'h1);
         apb(1'b0, `URS_OFS_DATA, 32'h0);
         check(rd, 32'h0C3);
      end
      $display("test rejected start done");

      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, `URS_OFS_CTRL, 32'h1 | (k << 3));
         tx.send(9'h0FF, 8, 64, 1'b1, -1, 0);
         apb(1'b0, `URS_OFS_DATA, 32'h0);
         apb(1'b1, `URS_OFS_STAT, 32'hE);
         repeat (240) @(posedge clk);
         apb(1'b0, `URS_OFS_STAT, 32'h0);
         check({31'h0, rd[3]}, 32'(k == 0));
         repeat (500) @(posedge clk);
         apb(1'b0, `URS_OFS_STAT, 32'h0);
         check(rd & 32'hF, 32'h8);
      end
      $display("test idle type done");

      apb(1'b1, `URS_OFS_STAT, 32'hE);
      apb(1'b1, `URS_OFS_CTRL, 32'h19);
      apb(1'b0, `URS_OFS_STAT, 32'h0);
      check(rd & 32'h2F, 32'h0);
      tx.send(9'h012, 8, 64, 1'b1, -1, 0);
      waitFull();
      apb(1'b1, `URS_OFS_CTRL, 32'h19);
      @(posedge clk);
      check({31'h0, rxEventReq}, 32'h0);
      apb(1'b0, `URS_OFS_DATA, 32'h0);
      check(rd, 32'h012);
      tx.send(9'h034, 8, 64, 1'b1, -1, 0);
      repeat (900) @(posedge clk);
      apb(1'b0, `URS_OFS_STAT, 32'h0);
      check(rd & 32'h3F, 32'h0);
      $display("test idle wakeup done");

      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, `URS_OFS_CTRL, amCtl[k]);
         tx.send(amDrop[k], 8 + k, 64, 1'b1, -1, 0);
         repeat (20) @(posedge clk);
         apb(1'b0, `URS_OFS_STAT, 32'h0);
         check(rd & 32'h21, 32'h20);
         tx.send(amWake[k], 8 + k, 64, 1'b1, -1, 0);
         waitFull();
         check(rd & 32'h21, 32'h1);
         apb(1'b0, `URS_OFS_DATA, 32'h0);
         check(rd, {23'h0, amWake[k]});
      end
      $display("test address mark done");
      end_of_test();
   end
endmodule : uart_rx_sampling_wakeup_tb_top
